//--- shared/hyst_pwr_pkg.sv
/*
 * Constants, field layout, reset values and types of the alarm hysteresis
 * and power control register bank.
 * Assumes an APB slave with 32-bit data; each register is one aligned word.
 */
package hyst_pwr_pkg;

	localparam int unsigned ADDR_W   = 12;
	localparam int unsigned REG_W    = 16;
	localparam int unsigned NUM_REGS = 4;
	localparam int unsigned NUM_OUTC = 12;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_ANALOG_HYST_CH01 = 8'h68;
	localparam logic [7:0] IDX_ANALOG_HYST_CH23 = 8'h69;
	localparam logic [7:0] IDX_TEMP_HYST        = 8'h6A;
	localparam logic [7:0] IDX_POWER_CONTROL    = 8'h6B;

	// one-hot select positions
	localparam int unsigned SEL_CH01  = 0;
	localparam int unsigned SEL_CH23  = 1;
	localparam int unsigned SEL_TEMP  = 2;
	localparam int unsigned SEL_POWER = 3;

	localparam logic [REG_W-1:0] RST_ANALOG_HYST = 16'h0810;
	localparam logic [REG_W-1:0] RST_TEMP_HYST   = 16'h2108;
	localparam logic [REG_W-1:0] RST_POWER       = 16'h0000;

	// bits that can hold a one; all others read zero
	localparam logic [REG_W-1:0] MASK_ANALOG = 16'h7FFE;
	localparam logic [REG_W-1:0] MASK_TEMP   = 16'h7FFF;
	localparam logic [REG_W-1:0] MASK_POWER  = 16'h7FFE;

	// analog hysteresis fields
	localparam int unsigned AHYS_W     = 7;
	localparam int unsigned AHYS_HI_LSB = 8;
	localparam int unsigned AHYS_LO_LSB = 1;

	// temperature hysteresis fields, stored as value bits 7:3
	localparam int unsigned THYS_W       = 5;
	localparam int unsigned THYS_VAL_W   = 8;
	localparam int unsigned THYS_ZERO_W  = 3;
	localparam int unsigned THYS_R2_LSB  = 10;
	localparam int unsigned THYS_R1_LSB  = 5;
	localparam int unsigned THYS_LOC_LSB = 0;

	// power control fields
	localparam int unsigned PWR_CONV_BIT   = 14;
	localparam int unsigned PWR_REFBUF_BIT = 13;
	localparam int unsigned PWR_OUTC0_BIT  = 12;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_SETUP = 3'b010,
		ST_DONE  = 3'b100
	} bus_state_t;

	typedef struct packed {
		bus_state_t       st;
		logic [REG_W-1:0] ahys01;
		logic [REG_W-1:0] ahys23;
		logic [REG_W-1:0] thys;
		logic [REG_W-1:0] pwr;
		logic [31:0]      rdata;
	} bank_state_t;

endpackage : hyst_pwr_pkg

//--- logic/hyst_addr_decode.sv
/*
 * Address decoder of the register bank: one-hot select and hit flag.
 * Assumes a byte address from APB; the two low bits are ignored.
 */
`timescale 1ns/1ns
module hyst_addr_decode
	import hyst_pwr_pkg::*;
(
	input  wire logic [hyst_pwr_pkg::ADDR_W-1:0]   paddr,  // bus byte address
	output logic      [hyst_pwr_pkg::NUM_REGS-1:0] sel,    // one-hot register select
	output logic                                   hit     // address is mapped
);
	import hyst_pwr_pkg::*;

	function automatic logic idx_match(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
		idx_match = (a[ADDR_W-1:2] == {{(ADDR_W-10){1'b0}}, idx});
	endfunction : idx_match

	always_comb begin
		sel            = '0;
		sel[SEL_CH01]  = idx_match(paddr, IDX_ANALOG_HYST_CH01);
		sel[SEL_CH23]  = idx_match(paddr, IDX_ANALOG_HYST_CH23);
		sel[SEL_TEMP]  = idx_match(paddr, IDX_TEMP_HYST);
		sel[SEL_POWER] = idx_match(paddr, IDX_POWER_CONTROL);
		hit            = |sel;
	end

endmodule : hyst_addr_decode

//--- logic/hyst_pwr_regs.sv
/*
 * Alarm hysteresis and power control register bank behind an APB slave.
 * Assumes a single clock pclk and asynchronous active-low presetn; APB
 * signals come from logic on pclk, so they are not synchronised.
 */
// Implementation choice: the APB register port.
`timescale 1ns/1ns
module hyst_pwr_regs
	import hyst_pwr_pkg::*;
(
	input  wire logic                                pclk,               // bus clock
	input  wire logic                                presetn,            // async reset, low
	input  wire logic                                psel,               // slave select
	input  wire logic                                penable,            // access phase
	input  wire logic                                pwrite,             // write when high
	input  wire logic [hyst_pwr_pkg::ADDR_W-1:0]     paddr,              // byte address
	input  wire logic [31:0]                         pwdata,             // write data
	input  wire logic [3:0]                          pstrb,              // byte lanes
	output logic      [31:0]                         prdata,             // read data
	output logic                                     pready,             // transfer done
	output logic                                     pslverr,            // unmapped access
	output logic      [hyst_pwr_pkg::AHYS_W-1:0]     input0_hyst,        // codes
	output logic      [hyst_pwr_pkg::AHYS_W-1:0]     input1_hyst,        // codes
	output logic      [hyst_pwr_pkg::AHYS_W-1:0]     input2_hyst,        // codes
	output logic      [hyst_pwr_pkg::AHYS_W-1:0]     input3_hyst,        // codes
	output logic      [hyst_pwr_pkg::THYS_VAL_W-1:0] remote2_temp_hyst,  // degrees
	output logic      [hyst_pwr_pkg::THYS_VAL_W-1:0] remote1_temp_hyst,  // degrees
	output logic      [hyst_pwr_pkg::THYS_VAL_W-1:0] local_temp_hyst,    // degrees
	output logic                                     converter_power_on, // converter on
	output logic                                     refbuf_power_on,    // ref buffer on
	output logic      [hyst_pwr_pkg::NUM_OUTC-1:0]   outconv_power_on,   // per converter
	output logic      [hyst_pwr_pkg::NUM_OUTC-1:0]   outconv_pin_ground  // pin to ground
);
	import hyst_pwr_pkg::*;

	bank_state_t           s_q;
	bank_state_t           s_d;
	logic [NUM_REGS-1:0]   sel;
	logic                  hit;
	logic                  setup_ph;
	logic                  access_ph;
	logic                  commit;
	logic [REG_W-1:0]      lane_mask;
	logic [REG_W-1:0]      rd_val;

	hyst_addr_decode i_hyst_addr_decode (
		.paddr (paddr),
		.sel   (sel),
		.hit   (hit)
	);

	// merges the write data into one register through its writable mask
	function automatic logic [REG_W-1:0] merge(
		input logic [REG_W-1:0] old,
		input logic [REG_W-1:0] wdat,
		input logic [REG_W-1:0] lanes,
		input logic [REG_W-1:0] keep
	);
		logic [REG_W-1:0] m;
		m     = lanes & keep;
		merge = ((old & ~m) | (wdat & m)) & keep;
	endfunction : merge

	// widens a stored five-bit field to its eight-bit value
	function automatic logic [THYS_VAL_W-1:0] temp_val(input logic [THYS_W-1:0] f);
		temp_val = {f, {THYS_ZERO_W{1'b0}}};
	endfunction : temp_val

	assign setup_ph  = psel & ~penable;
	assign access_ph = psel & penable;
	// zero-wait slave: every access phase ends in its first cycle
	assign pready    = 1'b1;
	assign pslverr   = access_ph & ~hit;
	// a stray penable without a setup cycle commits nothing
	assign commit    = access_ph & hit & pwrite & (s_q.st == ST_SETUP);
	assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

	always_comb begin
		rd_val = '0;
		unique case (1'b1)
			sel[SEL_CH01]:  rd_val = s_q.ahys01;
			sel[SEL_CH23]:  rd_val = s_q.ahys23;
			sel[SEL_TEMP]:  rd_val = s_q.thys;
			sel[SEL_POWER]: rd_val = s_q.pwr;
			default:        rd_val = '0;
		endcase
	end

	always_comb begin
		s_d = s_q;

		unique case (s_q.st)
			ST_IDLE: begin
				if (setup_ph) begin
					s_d.st = ST_SETUP;
				end
			end
			ST_SETUP: begin
				if (access_ph) begin
					s_d.st = ST_DONE;
				end else if (!psel) begin
					s_d.st = ST_IDLE;
				end
			end
			ST_DONE: begin
				s_d.st = setup_ph ? ST_SETUP : ST_IDLE;
			end
			default: s_d.st = ST_IDLE;
		endcase

		// read data is sampled in the setup cycle so prdata comes from a flop
		if (setup_ph) begin
			s_d.rdata = {16'h0000, rd_val};
		end

		if (commit) begin
			if (sel[SEL_CH01]) begin
				s_d.ahys01 = merge(s_q.ahys01, pwdata[REG_W-1:0], lane_mask, MASK_ANALOG);
			end
			if (sel[SEL_CH23]) begin
				s_d.ahys23 = merge(s_q.ahys23, pwdata[REG_W-1:0], lane_mask, MASK_ANALOG);
			end
			if (sel[SEL_TEMP]) begin
				s_d.thys = merge(s_q.thys, pwdata[REG_W-1:0], lane_mask, MASK_TEMP);
			end
			if (sel[SEL_POWER]) begin
				s_d.pwr = merge(s_q.pwr, pwdata[REG_W-1:0], lane_mask, MASK_POWER);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q.st     <= ST_IDLE;
			s_q.ahys01 <= RST_ANALOG_HYST;
			s_q.ahys23 <= RST_ANALOG_HYST;
			s_q.thys   <= RST_TEMP_HYST;
			s_q.pwr    <= RST_POWER;
			s_q.rdata  <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.rdata;

	// analog channels: one converter code per step
	assign input0_hyst = s_q.ahys01[AHYS_HI_LSB +: AHYS_W];
	assign input1_hyst = s_q.ahys01[AHYS_LO_LSB +: AHYS_W];
	assign input2_hyst = s_q.ahys23[AHYS_HI_LSB +: AHYS_W];
	assign input3_hyst = s_q.ahys23[AHYS_LO_LSB +: AHYS_W];

	// eight-bit value with three zero low bits; top reaches 248 with field 31
	assign remote2_temp_hyst = temp_val(s_q.thys[THYS_R2_LSB +: THYS_W]);
	assign remote1_temp_hyst = temp_val(s_q.thys[THYS_R1_LSB +: THYS_W]);
	assign local_temp_hyst   = temp_val(s_q.thys[THYS_LOC_LSB +: THYS_W]);

	assign converter_power_on = s_q.pwr[PWR_CONV_BIT];
	assign refbuf_power_on    = s_q.pwr[PWR_REFBUF_BIT];

	// converter 0 sits in the highest bit, so the order is reversed
	genvar gi;
	generate
		for (gi = 0; gi < NUM_OUTC; gi++) begin : g_outc
			assign outconv_power_on[gi]   = s_q.pwr[PWR_OUTC0_BIT - gi];
			assign outconv_pin_ground[gi] = ~s_q.pwr[PWR_OUTC0_BIT - gi];
		end
	endgenerate

endmodule : hyst_pwr_regs

//--- tb/hyst_pwr_asserts.sv
/* Checker for the hysteresis and power control bank.
   Bound to hyst_pwr_regs below; sees its ports only. */
`timescale 1ns/1ns
module hyst_pwr_asserts
	import hyst_pwr_pkg::*;
(
	input wire logic                  pclk,               // clk
	input wire logic                  presetn,            // rst
	input wire logic                  psel,               // sel
	input wire logic                  penable,            // en
	input wire logic                  pwrite,             // wr
	input wire logic [hyst_pwr_pkg::ADDR_W-1:0]     paddr,              // addr
	input wire logic [31:0]           pwdata,             // wdata
	input wire logic [3:0]            pstrb,              // lanes
	input wire logic [31:0]           prdata,             // rdata
	input wire logic                  pready,             // ready
	input wire logic                  pslverr,            // err
	input wire logic [hyst_pwr_pkg::AHYS_W-1:0]     input0_hyst,        // in0
	input wire logic [hyst_pwr_pkg::AHYS_W-1:0]     input1_hyst,        // in1
	input wire logic [hyst_pwr_pkg::AHYS_W-1:0]     input2_hyst,        // in2
	input wire logic [hyst_pwr_pkg::AHYS_W-1:0]     input3_hyst,        // in3
	input wire logic [hyst_pwr_pkg::THYS_VAL_W-1:0] remote2_temp_hyst,  // r2
	input wire logic [hyst_pwr_pkg::THYS_VAL_W-1:0] remote1_temp_hyst,  // r1
	input wire logic [hyst_pwr_pkg::THYS_VAL_W-1:0] local_temp_hyst,    // loc
	input wire logic                                converter_power_on, // adc
	input wire logic                                refbuf_power_on,    // ref
	input wire logic [hyst_pwr_pkg::NUM_OUTC-1:0]   outconv_power_on,   // outs
	input wire logic [hyst_pwr_pkg::NUM_OUTC-1:0]   outconv_pin_ground  // gnd
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	function automatic logic [11:0] rev12(input logic [11:0] v);
		for (int i = 0; i < 12; i++) rev12[i] = v[11-i];
	endfunction : rev12
	wire       acc = psel && penable;
	wire       wr  = acc && pwrite && pstrb[1:0] == 2'h3;
	wire [9:0] idx = paddr[11:2];
	a_pready_always: assert property (pready) else $error("pready low");
	a_pslverr_map: assert property (acc |-> pslverr == (paddr[11:4] != 8'h1A)) else $error("pslverr wrong");
	a_in01_write: assert property (wr && idx == 10'h068 |=> {input0_hyst, input1_hyst} == $past(pwdata[14:1]))
		else $error("input 0/1 field wrong");
	a_in23_write: assert property (wr && idx == 10'h069 |=> {input2_hyst, input3_hyst} == $past(pwdata[14:1]))
		else $error("input 2/3 field wrong");
	a_temp_write: assert property (wr && idx == 10'h06A |=> {remote2_temp_hyst[7:3], remote1_temp_hyst[7:3],
		local_temp_hyst[7:3]} == $past(pwdata[14:0])) else $error("temp field wrong");
	a_temp_lowzero: assert property (((remote2_temp_hyst | remote1_temp_hyst | local_temp_hyst) & 8'h07) == 8'h00)
		else $error("temp low bits set");
	a_power_write: assert property (wr && idx == 10'h06B |=> {converter_power_on, refbuf_power_on,
		rev12(outconv_power_on)} == $past(pwdata[14:1])) else $error("power bits wrong");
	a_ground_inverse: assert property (outconv_pin_ground == ~outconv_power_on) else $error("ground wrong");
	a_reset_values: assert property ($rose(presetn) |-> input0_hyst == 7'h08 && input3_hyst == 7'h08
		&& local_temp_hyst == 8'h40 && remote2_temp_hyst == 8'h40 && outconv_power_on == 12'h000) else $error("reset wrong");
	a_read_upper: assert property (acc && !pwrite |-> prdata[31:15] == 17'h0) else $error("upper bits set");
	c_power_write: cover property (wr && idx == 10'h06B);
	c_unmapped: cover property (acc && pslverr);
	c_read: cover property (acc && !pwrite);
endmodule : hyst_pwr_asserts
bind hyst_pwr_regs hyst_pwr_asserts i_hyst_pwr_asserts (
	.pclk               (pclk),
	.presetn            (presetn),
	.psel               (psel),
	.penable            (penable),
	.pwrite             (pwrite),
	.paddr              (paddr),
	.pwdata             (pwdata),
	.pstrb              (pstrb),
	.prdata             (prdata),
	.pready             (pready),
	.pslverr            (pslverr),
	.input0_hyst        (input0_hyst),
	.input1_hyst        (input1_hyst),
	.input2_hyst        (input2_hyst),
	.input3_hyst        (input3_hyst),
	.remote2_temp_hyst  (remote2_temp_hyst),
	.remote1_temp_hyst  (remote1_temp_hyst),
	.local_temp_hyst    (local_temp_hyst),
	.converter_power_on (converter_power_on),
	.refbuf_power_on    (refbuf_power_on),
	.outconv_power_on   (outconv_power_on),
	.outconv_pin_ground (outconv_pin_ground)
);

//--- tb/tb_hyst_pwr_regs.sv
/* Self-checking bench for hyst_pwr_regs: APB traffic, shadow model, port checks.
   Assumes the package and the checker bind are compiled first. */
`timescale 1ns/1ns
module tb_hyst_pwr_regs;
	import hyst_pwr_pkg::*;
	logic                  pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [ADDR_W-1:0]     paddr = '0;
	logic [31:0]           pwdata = '0, prdata;
	logic [3:0]            pstrb = '0;
	logic                  pready, pslverr, converter_power_on, refbuf_power_on;
	logic [AHYS_W-1:0]     input0_hyst, input1_hyst, input2_hyst, input3_hyst;
	logic [THYS_VAL_W-1:0] remote2_temp_hyst, remote1_temp_hyst, local_temp_hyst;
	logic [NUM_OUTC-1:0]   outconv_power_on, outconv_pin_ground;
	logic [REG_W-1:0]      m [4];
	logic [32:0]           q [$];
	int                    err_count = 0, check_count = 0;
	hyst_pwr_regs i_hyst_pwr_regs (
		.pclk               (pclk),
		.presetn            (presetn),
		.psel               (psel),
		.penable            (penable),
		.pwrite             (pwrite),
		.paddr              (paddr),
		.pwdata             (pwdata),
		.pstrb              (pstrb),
		.prdata             (prdata),
		.pready             (pready),
		.pslverr            (pslverr),
		.input0_hyst        (input0_hyst),
		.input1_hyst        (input1_hyst),
		.input2_hyst        (input2_hyst),
		.input3_hyst        (input3_hyst),
		.remote2_temp_hyst  (remote2_temp_hyst),
		.remote1_temp_hyst  (remote1_temp_hyst),
		.local_temp_hyst    (local_temp_hyst),
		.converter_power_on (converter_power_on),
		.refbuf_power_on    (refbuf_power_on),
		.outconv_power_on   (outconv_power_on),
		.outconv_pin_ground (outconv_pin_ground)
	);
	always #5 pclk = ~pclk;
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	// readable bits per register; index 2 keeps bit 0
	function automatic logic [REG_W-1:0] mv(input int i);
		return m[i] & (i == 2 ? 16'h7FFF : 16'h7FFE);
	endfunction : mv
	// request held until pready; release left to caller so transfers can chain
	task automatic apb(input logic w, input int i, input logic [15:0] d, input logic [3:0] s);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= 12'h1A0 + 12'(i * 4);
		pwdata <= {16'hA5A5, d};
		pstrb <= s;
		q.push_back({i > 3, i > 3 ? 32'h0 : {16'h0, mv(i)}});
		if (w && i < 4) for (int b = 0; b < 2; b++) if (s[b]) m[i][b*8 +: 8] = d[b*8 +: 8];
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
	endtask : apb
	task automatic idle;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : idle
	always @(posedge pclk) if (psel && penable && pready === 1'b1) begin
		logic [32:0] e;
		e = q.pop_front();
		cmp({31'h0, pslverr}, {31'h0, e[32]});
		if (!pwrite) cmp(prdata, e[31:0]);
	end
	task automatic chk_out;
		cmp({input0_hyst, input1_hyst}, {m[0][14:8], m[0][7:1]});
		cmp({input2_hyst, input3_hyst}, {m[1][14:8], m[1][7:1]});
		cmp({remote2_temp_hyst, remote1_temp_hyst, local_temp_hyst}, {m[2][14:10], 3'h0, m[2][9:5], 3'h0, m[2][4:0], 3'h0});
		cmp({converter_power_on, refbuf_power_on}, m[3][14:13]);
		for (int n = 0; n < 12; n++) cmp({outconv_power_on[n], outconv_pin_ground[n]}, {m[3][12-n], !m[3][12-n]});
	endtask : chk_out
	task automatic rst;
		presetn <= 1'b0;
		m = '{16'h0810, 16'h0810, 16'h2108, 16'h0000};
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk_out();
		for (int i = 0; i < 5; i++) apb(1'b0, i, 16'h0, 4'h0);
		idle();
	endtask : rst
	task automatic close_out;
		$display("Checks %0d, errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : close_out
	initial begin
		#200000;
		err_count++;
		close_out();
	end
	initial begin
		void'($urandom(32'h78a1e823));
		rst();
		apb(1'b1, 0, 16'($urandom), 4'h3);
		apb(1'b1, 1, 16'($urandom), 4'h3);
		apb(1'b1, 2, 16'hFFFF, 4'hF);
		apb(1'b1, 3, 16'hFFFF, 4'h3);
		idle();
		chk_out();
		for (int k = 0; k < 80; k++) begin
			int i;
			i = $urandom_range(4);
			apb(1'b1, i, 16'($urandom), 4'($urandom));
			apb(1'b0, i, 16'h0, 4'h0);
			apb(1'b0, $urandom_range(4), 16'h0, 4'h0);
			idle();
			chk_out();
		end
		rst();
		close_out();
	end
endmodule : tb_hyst_pwr_regs
